// ---- common/plcs_irq_if.sv ----
`timescale 1ns/10ps
`include "plcs_params.svh"

interface plcs_irq_if;
  logic [`PLCS_IRQ_N-1:0] ev;
  logic [`PLCS_IRQ_N-1:0] clr;
  logic [`PLCS_IRQ_N-1:0] mask;
  logic [`PLCS_IRQ_N-1:0] status;
  logic                   irq;

  modport core
  (
    output ev,
    output clr,
    output mask,
    input  status,
    input  irq
  );

  modport unit
  (
    input  ev,
    input  clr,
    input  mask,
    output status,
    output irq
  );
endinterface : plcs_irq_if

// ---- common/plcs_params.svh ----
`ifndef PLCS_PARAMS_SVH
`define PLCS_PARAMS_SVH

// Register byte addresses on the APB window
`define PLCS_OFS_LINK      12'h0d0
`define PLCS_OFS_IRQ_ST    12'h0e0
`define PLCS_OFS_IRQ_MASK  12'h0e4
`define PLCS_OFS_SLOT_CLOCK_STRAP   12'h0e8

// Link control field positions (low half of the word)
`define PLCS_B_ASPM_LO     0
`define PLCS_B_ASPM_HI     1
`define PLCS_B_RCB         3
`define PLCS_B_DIS         4
`define PLCS_B_RETRAIN     5
`define PLCS_B_CCLK        6
`define PLCS_B_ESYNC       7
`define PLCS_B_HAWD        9
`define PLCS_B_DS10        10
`define PLCS_B_DS11        11

// Link status field positions (high half of the word)
`define PLCS_B_SPEED_LO    16
`define PLCS_B_SPEED_HI    19
`define PLCS_B_WIDTH_LO    20
`define PLCS_B_WIDTH_HI    25
`define PLCS_B_TERR        26
`define PLCS_B_TRAIN       27
`define PLCS_B_SLOT_CLOCK_STRAP     28
`define PLCS_B_DLACT       29

// Codes and reset values
`define PLCS_ASPM_OFF      2'h0
`define PLCS_SPEED_2G5     4'h1
`define PLCS_SPEED_5G0     4'h2
`define PLCS_WIDTH_X1      6'h01

// Ordered-set counts for leaving low-power states
`define PLCS_FTS_EXT       13'h1000
`define PLCS_TS1_EXT       11'h400
`define PLCS_FTS_NORM      13'h0040
`define PLCS_TS1_NORM      11'h010

// Interrupt status bits
`define PLCS_IRQ_TERR      0
`define PLCS_IRQ_TDONE     1
`define PLCS_IRQ_DLCHG     2
`define PLCS_IRQ_N         3

`endif

// ---- common/plcs_pkg.sv ----
package plcs_pkg;

  // Writable state of the link control register
  typedef struct packed {
    logic [1:0] aspm;
    logic       dis;
    logic       cclk;
    logic       esync;
    logic       hawd;
    logic       ds10;
    logic       ds11;
  } plcs_ctrl_s;

  typedef logic [2:0] plcs_irq_t;

endpackage : plcs_pkg

// ---- hdl/plcs_irq.sv ----
`timescale 1ns/10ps
`include "plcs_params.svh"

module plcs_irq
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Event and status link to the register core
  plcs_irq_if.unit irq_if
);

  logic [`PLCS_IRQ_N-1:0] st_q;

  genvar i;
  generate
    for (i = 0; i < `PLCS_IRQ_N; i++)
    begin : g_bit
      // Set beats clear so an event in the clearing cycle is kept
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          st_q[i] <= 1'b0;
        else if (irq_if.ev[i])
          st_q[i] <= 1'b1;
        else if (irq_if.clr[i])
          st_q[i] <= 1'b0;
      end
    end
  endgenerate

  assign irq_if.status = st_q;
  assign irq_if.irq    = |(st_q & irq_if.mask);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_set_wins;
    irq_if.ev[`PLCS_IRQ_TERR] |=> st_q[`PLCS_IRQ_TERR];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost in interrupt status");

endmodule : plcs_irq

// ---- hdl/plcs_link_regs.sv ----
`timescale 1ns/10ps
`include "plcs_params.svh"

// What this block does
// - Two-bit power field picks none, L0s, L1 or both; resets to none.
// - Receiver may always enter L0s whatever the power field says.
// - Read completion boundary bit is read-only and reads zero.
// - Link disable is zero on upstream; downstream it takes the link down.
// - Retrain is zero upstream; downstream a one starts retraining; reads zero.
// - Common clock bit is writable, resets to zero, tells the clocking.
// - Extended sync asks for 4096 FTS and 1024 TS1 sets on exit.
// - Bits ten and eleven read zero upstream, read-write downstream.
// - Current speed reports 2.5 or 5.0 Gb/s, resets to 5.0 code.
// - Negotiated width reports trained width, resets to one-lane code.
// - Training error sets on failure, clears on entering L0, resets zero.
// - Training flag is one while training runs, resets to zero.
// - Slot clock bit loads from strap, software may override it.
// - Link active reads one only while the link layer is active.

module plcs_link_regs
#(
  parameter bit UPSTREAM = 1'b0
)
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Training machine status
  input  wire logic        lt_training,
  input  wire logic        lt_fail,
  input  wire logic        lt_in_l0,
  input  wire logic [3:0]  lt_speed,
  input  wire logic [5:0]  lt_width,
  input  wire logic        dl_active,
  input  wire logic        slot_clock_strap,
  // Training machine control
  output logic             link_disable,
  output logic             retrain_req,
  output logic             aspm_l0s_tx_en,
  output logic             aspm_l1_en,
  output logic             rx_l0s_en,
  output logic             common_clock,
  output logic             ext_synch,
  output logic [12:0]      fts_sets,
  output logic [10:0]      ts1_sets,
  output logic             hw_width_dis,
  // Interrupt
  output logic             irq
);

  plcs_pkg::plcs_ctrl_s   ctrl_q;
  plcs_pkg::plcs_ctrl_s   ctrl_d;
  plcs_pkg::plcs_irq_t    mask_q;
  logic                   retrain_q;
  logic [3:0]             speed_q;
  logic [5:0]             width_q;
  logic                   terr_q;
  logic                   train_q;
  logic                   dlact_q;
  logic                   slot_clock_strap_q;
  logic                   strap_done_q;
  logic [31:0]            prdata_q;

  plcs_irq_if irq_if ();

  plcs_irq u_irq
  (
    .pclk    (pclk),
    .presetn (presetn),
    .irq_if  (irq_if.unit)
  );

  // Bus decode
  wire        setup_rd = psel & ~penable & ~pwrite;
  wire        wr_en    = psel & penable & pwrite;
  wire        sel_link = (paddr == `PLCS_OFS_LINK);
  wire        sel_st   = (paddr == `PLCS_OFS_IRQ_ST);
  wire        sel_mask = (paddr == `PLCS_OFS_IRQ_MASK);
  wire        sel_slot = (paddr == `PLCS_OFS_SLOT_CLOCK_STRAP);
  wire        hit      = sel_link | sel_st | sel_mask | sel_slot;
  wire        lo_we    = wr_en & sel_link & pstrb[0];
  wire        hi_we    = wr_en & sel_link & pstrb[1];
  wire        st_we    = wr_en & sel_st & pstrb[0];
  wire        mask_we  = wr_en & sel_mask & pstrb[0];
  wire        slot_we  = wr_en & sel_slot & pstrb[0];

  // Control register next value; fixed bits never take write data
  assign ctrl_d.aspm  = lo_we ? pwdata[`PLCS_B_ASPM_HI:`PLCS_B_ASPM_LO]
                              : ctrl_q.aspm;
  assign ctrl_d.dis   = UPSTREAM ? 1'b0
                      : (lo_we ? pwdata[`PLCS_B_DIS] : ctrl_q.dis);
  assign ctrl_d.cclk  = lo_we ? pwdata[`PLCS_B_CCLK] : ctrl_q.cclk;
  assign ctrl_d.esync = lo_we ? pwdata[`PLCS_B_ESYNC] : ctrl_q.esync;
  assign ctrl_d.hawd  = hi_we ? pwdata[`PLCS_B_HAWD] : ctrl_q.hawd;
  assign ctrl_d.ds10  = UPSTREAM ? 1'b0
                      : (hi_we ? pwdata[`PLCS_B_DS10] : ctrl_q.ds10);
  assign ctrl_d.ds11  = UPSTREAM ? 1'b0
                      : (hi_we ? pwdata[`PLCS_B_DS11] : ctrl_q.ds11);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= '0;
    else
      ctrl_q <= ctrl_d;
  end

  // Retrain is a one-cycle request and is never stored for readback
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      retrain_q <= 1'b0;
    else
      retrain_q <= ~UPSTREAM & lo_we & pwdata[`PLCS_B_RETRAIN];
  end

  // Speed and width are only meaningful once training lands in L0
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      speed_q <= `PLCS_SPEED_5G0;
      width_q <= `PLCS_WIDTH_X1;
    end
    else if (lt_in_l0)
    begin
      speed_q <= lt_speed;
      width_q <= lt_width;
    end
  end

  // A failure in the same cycle as L0 entry keeps the error visible
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      terr_q <= 1'b0;
    else if (lt_fail)
      terr_q <= 1'b1;
    else if (lt_in_l0)
      terr_q <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      train_q <= 1'b0;
      dlact_q <= 1'b0;
    end
    else
    begin
      train_q <= lt_training;
      dlact_q <= dl_active;
    end
  end

  // Strap is caught on the first edge after reset release, not by reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slot_clock_strap_q    <= 1'b0;
      strap_done_q <= 1'b0;
    end
    else if (!strap_done_q)
    begin
      slot_clock_strap_q    <= slot_clock_strap;
      strap_done_q <= 1'b1;
    end
    else if (slot_we)
      slot_clock_strap_q <= pwdata[0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_q <= '0;
    else if (mask_we)
      mask_q <= pwdata[`PLCS_IRQ_N-1:0];
  end

  // Interrupt events and write-one-to-clear
  wire [`PLCS_IRQ_N-1:0] ev_w = {dl_active ^ dlact_q,
                                 train_q & ~lt_training,
                                 lt_fail};
  assign irq_if.ev   = ev_w;
  assign irq_if.clr  = st_we ? pwdata[`PLCS_IRQ_N-1:0] : '0;
  assign irq_if.mask = mask_q;

  // Read data; every unnamed bit is reserved and reads zero
  wire [15:0] ctrl_rd = {4'h0, ctrl_q.ds11, ctrl_q.ds10, ctrl_q.hawd, 1'b0,
                         ctrl_q.esync, ctrl_q.cclk, 1'b0, ctrl_q.dis,
                         1'b0, 1'b0, ctrl_q.aspm};
  wire [15:0] stat_rd = {2'h0, dlact_q, slot_clock_strap_q, train_q, terr_q,
                         width_q, speed_q};
  wire [31:0] rd_mux  = sel_link ? {stat_rd, ctrl_rd}
                      : sel_st   ? {29'h0, irq_if.status}
                      : sel_mask ? {29'h0, mask_q}
                      : sel_slot ? {31'h0, slot_clock_strap_q}
                      : 32'h0;

  // Read data is captured in setup so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0;
    else if (setup_rd)
      prdata_q <= rd_mux;
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // Link-side controls
  assign link_disable   = ctrl_q.dis;
  assign retrain_req    = retrain_q;
  assign aspm_l0s_tx_en = ctrl_q.aspm[0];
  assign aspm_l1_en     = ctrl_q.aspm[1];
  assign rx_l0s_en      = 1'b1;
  assign common_clock   = ctrl_q.cclk;
  assign ext_synch      = ctrl_q.esync;
  assign fts_sets       = ctrl_q.esync ? `PLCS_FTS_EXT
                                       : `PLCS_FTS_NORM;
  assign ts1_sets       = ctrl_q.esync ? `PLCS_TS1_EXT
                                       : `PLCS_TS1_NORM;
  assign hw_width_dis   = ctrl_q.hawd;
  assign irq            = irq_if.irq;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_wr_lo;
    psel && penable && pwrite && sel_link && pstrb[0];
  endsequence

  sequence s_rd_link;
    psel && !penable && !pwrite && sel_link;
  endsequence

  property p_aspm_write;
    s_wr_lo |=> (aspm_l0s_tx_en == $past(pwdata[`PLCS_B_ASPM_LO]))
             && (aspm_l1_en == $past(pwdata[`PLCS_B_ASPM_HI]));
  endproperty
  a_aspm_write: assert property (p_aspm_write)
    else $error("power field did not follow write");

  property p_rx_l0s;
    rx_l0s_en && (aspm_l0s_tx_en == ctrl_q.aspm[0]);
  endproperty
  a_rx_l0s: assert property (p_rx_l0s)
    else $error("receiver L0s blocked");

  property p_rsvd_zero;
    s_rd_link |=> !prdata[`PLCS_B_RCB] && !prdata[`PLCS_B_RETRAIN]
               && !prdata[2] && !prdata[8] && (prdata[15:12] == 4'h0)
               && (prdata[31:30] == 2'h0);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("fixed or reserved bit read non-zero");

  property p_disable;
    s_wr_lo |=> (link_disable == (!UPSTREAM && $past(pwdata[`PLCS_B_DIS])));
  endproperty
  a_disable: assert property (p_disable)
    else $error("link disable wrong after write");

  sequence s_retrain_pulse;
    retrain_req ##1 !retrain_req;
  endsequence

  property p_retrain;
    (s_wr_lo and pwdata[`PLCS_B_RETRAIN] && !UPSTREAM) |=> s_retrain_pulse;
  endproperty
  a_retrain: assert property (p_retrain)
    else $error("retrain request not a single pulse");

  property p_esync;
    ext_synch |-> (fts_sets == 13'h1000) && (ts1_sets == 11'h400);
  endproperty
  a_esync: assert property (p_esync)
    else $error("extended sync counts wrong");

  property p_speed;
    lt_in_l0 |=> (speed_q == $past(lt_speed)) && (width_q == $past(lt_width));
  endproperty
  a_speed: assert property (p_speed)
    else $error("speed or width not latched at L0");

  property p_terr;
    (lt_fail |=> terr_q) and ((lt_in_l0 && !lt_fail) |=> !terr_q);
  endproperty
  a_terr: assert property (p_terr)
    else $error("training error flag wrong");

  property p_train;
    train_q == $past(lt_training);
  endproperty
  a_train: assert property (p_train)
    else $error("training flag lags wrongly");

  property p_dlact;
    dl_active |-> ##1 (dlact_q ##1 1'b1);
  endproperty
  a_dlact: assert property (p_dlact)
    else $error("link active not reported");

  property p_irq;
    (ev_w[`PLCS_IRQ_TERR] && mask_q[`PLCS_IRQ_TERR] && !mask_we) |=> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("unmasked event raised no interrupt");

  property p_cclk;
    s_wr_lo |=> (common_clock == $past(pwdata[`PLCS_B_CCLK]));
  endproperty
  a_cclk: assert property (p_cclk)
    else $error("common clock bit did not follow write");

  sequence s_wr_hi;
    psel && penable && pwrite && sel_link && pstrb[1];
  endsequence

  // Upstream must keep bits ten and eleven at zero whatever is written
  property p_ds_bits;
    s_wr_hi |=> (ctrl_q.ds10 == (!UPSTREAM && $past(pwdata[`PLCS_B_DS10])))
             && (ctrl_q.ds11 == (!UPSTREAM && $past(pwdata[`PLCS_B_DS11])));
  endproperty
  a_ds_bits: assert property (p_ds_bits)
    else $error("bits ten or eleven wrong after write");

  property p_strap;
    $rose(strap_done_q) |-> (slot_clock_strap_q == $past(slot_clock_strap));
  endproperty
  a_strap: assert property (p_strap)
    else $error("slot clock bit missed the strap");

  property p_slot_write;
    (slot_we && strap_done_q) |=> (slot_clock_strap_q == $past(pwdata[0]));
  endproperty
  a_slot_write: assert property (p_slot_write)
    else $error("slot clock override not taken");

endmodule : plcs_link_regs

// ---- tb/plcs_link_regs_tb.sv ----
`timescale 1ns/10ps
`include "plcs_params.svh"

module plcs_link_regs_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, strap = 1'b1, fail_mode = 1'b0, up_dis, up_rt;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, prdata_up, rdv, rdv_up;
  logic pready, pslverr, errv, trn, fl, l0, dla, dis, rt, l0s, l1, rxl0s;
  logic cclk, esync, hawd, irq;
  logic [3:0] spd;
  logic [5:0] wid;
  logic [12:0] fts;
  logic [10:0] ts1;
  int n_mismatch = 0, samples_checked = 0, n_rt = 0, n_rt_up = 0;

  plcs_link_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lt_training(trn), .lt_fail(fl), .lt_in_l0(l0), .lt_speed(spd),
    .lt_width(wid), .dl_active(dla), .slot_clock_strap(strap),
    .link_disable(dis), .retrain_req(rt), .aspm_l0s_tx_en(l0s),
    .aspm_l1_en(l1), .rx_l0s_en(rxl0s), .common_clock(cclk),
    .ext_synch(esync), .fts_sets(fts), .ts1_sets(ts1),
    .hw_width_dis(hawd), .irq(irq));
  plcs_link_regs #(.UPSTREAM(1'b1)) dut_up (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata_up),
    .pready(), .pslverr(), .lt_training(trn), .lt_fail(fl),
    .lt_in_l0(l0), .lt_speed(spd), .lt_width(wid), .dl_active(dla),
    .slot_clock_strap(strap), .link_disable(up_dis), .retrain_req(up_rt),
    .aspm_l0s_tx_en(), .aspm_l1_en(), .rx_l0s_en(), .common_clock(),
    .ext_synch(), .fts_sets(), .ts1_sets(), .hw_width_dis(), .irq());
  plcs_partner far_u (.pclk(pclk), .presetn(presetn), .retrain_req(rt),
    .link_disable(dis), .fail_mode(fail_mode), .lt_training(trn),
    .lt_fail(fl), .lt_in_l0(l0), .lt_speed(spd), .lt_width(wid),
    .dl_active(dla));

  always #5 pclk = ~pclk;

  always @(posedge pclk)
  begin
    if (rt === 1'b1) n_rt++;
    if (up_rt === 1'b1) n_rt_up++;
  end

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      $display("unexpected at %0t: no bus answer", $time);
    end
    rdv = prdata;
    rdv_up = prdata_up;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let a register write settle before the caller looks at outputs
    @(posedge pclk);
  endtask : apb

  task t_reset;
    apb(1'b0, `PLCS_OFS_LINK, 32'h0);
    cmp(rdv, 32'h1012_0000);
    cmp({19'h0, fts}, 32'h40);
    cmp({30'h0, rxl0s, irq}, 32'h2);
  endtask : t_reset

  task t_ctrl;
    apb(1'b1, `PLCS_OFS_LINK, 32'hffff_ffdf);
    apb(1'b0, `PLCS_OFS_LINK, 32'h0);
    cmp(rdv, 32'h1012_0ed3);
    cmp(rdv_up, 32'h1012_02c3);
    cmp({27'h0, dis, cclk, esync, hawd, up_dis}, 32'h1e);
    cmp({fts, 8'h0, ts1}, {13'h1000, 8'h0, 11'h400});
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, `PLCS_OFS_LINK, 32'(i));
      cmp({29'h0, rxl0s, l1, l0s}, 32'(i + 4));
    end
  endtask : t_ctrl

  task t_retrain(input logic f, input logic [31:0] exp);
    int n;
    fail_mode <= f;
    apb(1'b1, `PLCS_OFS_LINK, 32'h23);
    repeat (3) @(posedge pclk);
    apb(1'b0, `PLCS_OFS_LINK, 32'h0);
    cmp(rdv & 32'h0800_0020, 32'h0800_0000);
    n = 0;
    do begin apb(1'b0, `PLCS_OFS_LINK, 32'h0); n++; end
    while (rdv[27] !== 1'b0 && n < 20);
    apb(1'b0, `PLCS_OFS_LINK, 32'h0);
    cmp(rdv & 32'h3fff_0000, exp);
    cmp(32'(n_rt_up), 32'h0);
  endtask : t_retrain

  task t_irq;
    apb(1'b0, `PLCS_OFS_IRQ_ST, 32'h0);
    cmp(rdv & 32'h7, 32'h3);
    cmp({31'h0, irq}, 32'h0);
    apb(1'b1, `PLCS_OFS_IRQ_MASK, 32'h1);
    cmp({31'h0, irq}, 32'h1);
    apb(1'b1, `PLCS_OFS_IRQ_MASK, 32'h2);
    apb(1'b1, `PLCS_OFS_IRQ_ST, 32'h3);
    cmp({31'h0, irq}, 32'h0);
    apb(1'b0, `PLCS_OFS_IRQ_ST, 32'h0);
    cmp(rdv & 32'h7, 32'h0);
  endtask : t_irq

  task t_misc;
    cmp({31'h0, irq}, 32'h1);
    apb(1'b0, 12'h0fc, 32'h0);
    cmp({rdv[30:0], errv}, 32'h1);
    apb(1'b1, `PLCS_OFS_SLOT_CLOCK_STRAP, 32'h0);
    apb(1'b1, `PLCS_OFS_LINK, 32'h10);
    repeat (3) @(posedge pclk);
    apb(1'b0, `PLCS_OFS_LINK, 32'h0);
    cmp(rdv & 32'h3000_0000, 32'h0);
    cmp(32'(n_rt), 32'h2);
  endtask : t_misc

  task stop_test;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  initial
  begin
    #200us;
    n_mismatch++;
    stop_test();
  end

  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_ctrl();
    t_retrain(1'b1, 32'h1412_0000);
    t_irq();
    t_retrain(1'b0, 32'h3011_0000);
    t_misc();
    stop_test();
  end
endmodule : plcs_link_regs_tb

// ---- tb/plcs_partner.sv ----
`timescale 1ns/10ps

module plcs_partner
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Requests from the port
  input  wire logic       retrain_req,
  input  wire logic       link_disable,
  input  wire logic       fail_mode,
  // Training results to the port
  output logic            lt_training,
  output logic            lt_fail,
  output logic            lt_in_l0,
  output logic [3:0]      lt_speed,
  output logic [5:0]      lt_width,
  output logic            dl_active
);
  logic [3:0] cnt_q;

  // Speed and width churn outside the L0 pulse to expose early sampling
  assign lt_speed = lt_in_l0 ? 4'h1 : ~cnt_q;
  assign lt_width = lt_in_l0 ? 6'h01 : {2'h3, cnt_q};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q       <= 4'h0;
      lt_training <= 1'b0;
      lt_fail     <= 1'b0;
      lt_in_l0    <= 1'b0;
      dl_active   <= 1'b0;
    end
    else
    begin
      lt_fail  <= 1'b0;
      lt_in_l0 <= 1'b0;
      if (retrain_req)
      begin
        lt_training <= 1'b1;
        cnt_q       <= 4'h8;
      end
      else if (lt_training)
      begin
        cnt_q <= cnt_q - 4'h1;
        if (cnt_q == 4'h1)
        begin
          lt_training <= 1'b0;
          lt_fail     <= fail_mode;
          lt_in_l0    <= !fail_mode;
        end
      end
      if (link_disable || lt_fail)
        dl_active <= 1'b0;
      else if (lt_in_l0)
        dl_active <= 1'b1;
    end
  end
endmodule : plcs_partner
